// *** cpm_top.sv ***
/*
 * Control pin and power-down mux: power-down handling, self-test and shared
 * interrupt pin decode, three multifunction general pins, Avalon-MM slave.
 * Assumes all pin inputs except power-down are synchronous to i_clock at 40 MHz.
 */
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`default_nettype none
`include "cpm_consts.svh"
module cpm_top (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_power_down_n_input,
    output var  logic        o_power_down_pulldown_en,
    output var  logic        o_pll_enable,
    output var  logic        o_low_power,
    output var  logic        o_running,
    input  wire logic        i_self_test_enable_pin,
    input  wire logic        i_self_test_clock_select,
    output var  logic        o_self_test_mode,
    output var  logic        o_test_clock_fixed,
    output var  logic        o_interrupt_input,
    input  wire logic        i_serial_audio_out,
    input  wire logic        i_self_test_pass,
    input  wire logic        i_alt_function_pin1,
    input  wire logic        i_audio_data_lane_c,
    input  wire logic [2:0]  i_general_io_i,
    output var  logic [2:0]  o_general_io_o,
    output var  logic [2:0]  o_general_io_oe,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output var  logic [31:0] o_avs_readdata,
    output var  logic        o_avs_waitrequest
);
    cpm_pkg::cpm_state_s state_reg;
    cpm_pkg::cpm_state_s state_next;
    logic                enabled;
    logic [2:0]          alt1;
    logic [2:0]          alt2;
    logic                req;

    // Drive value of a pin for its selected function
    function automatic logic cpm_pin_value(input logic [1:0] sel, input logic gpio_v,
                                           input logic a1, input logic a2);
        case (cpm_pkg::cpm_pin_func_e'(sel))
            cpm_pkg::CPM_FUNC_GPIO: cpm_pin_value = gpio_v;
            cpm_pkg::CPM_FUNC_ALT1: cpm_pin_value = a1;
            cpm_pkg::CPM_FUNC_ALT2: cpm_pin_value = a2;
            default:                cpm_pin_value = 1'b0;
        endcase
    endfunction

    // Whether a pin is driven for its selected function
    // General I/O role drives its pin only while its input enable is clear
    function automatic logic cpm_pin_drives(input logic [1:0] sel, input logic in_en);
        case (cpm_pkg::cpm_pin_func_e'(sel))
            cpm_pkg::CPM_FUNC_GPIO: cpm_pin_drives = ~in_en;
            cpm_pkg::CPM_FUNC_RSVD: cpm_pin_drives = 1'b0;
            default:                cpm_pin_drives = 1'b1;
        endcase
    endfunction

    // Power-down release onto the clock
    cpm_release_sync u_release_sync (
        .i_clock              (i_clock),
        .i_rst                (i_rst),
        .i_power_down_n_input (i_power_down_n_input),
        .o_enabled            (enabled)
    );

    // Alternate sources per pin; pin 1 and 2 have a single alternate
    assign alt1 = {i_audio_data_lane_c, i_alt_function_pin1, i_serial_audio_out};
    assign alt2 = {1'b0, 1'b0, i_self_test_pass};
    assign req  = i_avs_read | i_avs_write;

    // Next state: power, registers, bus answer and pin drive
    always_comb begin
        state_next = state_reg;
        // One-cycle answer: ack rises the cycle after a request
        state_next.ack = req & ~state_reg.ack;
        if (req && !state_reg.ack) begin
            case (i_avs_address)
                `CPM_ADDR_FUNC_SEL:  state_next.rdata = {26'h0, state_reg.func_sel};
                `CPM_ADDR_GPIO_CTRL: state_next.rdata = {25'h0, state_reg.gpio_in_en, 1'b0, state_reg.gpio_out};
                `CPM_ADDR_STATUS: begin
                    state_next.rdata = 32'h0;
                    state_next.rdata[`CPM_STAT_PIN_LSB +: 3] = i_general_io_i;
                    state_next.rdata[`CPM_STAT_SELFTEST] = state_reg.self_test;
                    state_next.rdata[`CPM_STAT_CLKFIX] = state_reg.clk_fixed;
                    state_next.rdata[`CPM_STAT_INT] = state_reg.int_in;
                    state_next.rdata[`CPM_STAT_RUN] = (state_reg.power == cpm_pkg::CPM_ST_RUN);
                end
                default: state_next.rdata = 32'h0;
            endcase
        end
        if (i_avs_write && state_reg.ack && i_avs_byteenable[0] && state_reg.power == cpm_pkg::CPM_ST_RUN) begin
            case (i_avs_address)
                `CPM_ADDR_FUNC_SEL: state_next.func_sel = i_avs_writedata[5:0];
                `CPM_ADDR_GPIO_CTRL: begin
                    state_next.gpio_out   = i_avs_writedata[`CPM_CTRL_OUT_LSB +: 3];
                    state_next.gpio_in_en = i_avs_writedata[`CPM_CTRL_INEN_LSB +: 3];
                end
                default: ;
            endcase
        end
        state_next.self_test = i_self_test_enable_pin;
        // Clock select only in self-test, interrupt otherwise
        state_next.clk_fixed = i_self_test_enable_pin & i_self_test_clock_select;
        state_next.int_in    = ~i_self_test_enable_pin & i_self_test_clock_select;
        for (int p = 0; p < 3; p++) begin
            state_next.pin_o[p]  = cpm_pin_value(state_reg.func_sel[p*2 +: 2], state_reg.gpio_out[p],
                                                 alt1[p], alt2[p]);
            state_next.pin_oe[p] = cpm_pin_drives(state_reg.func_sel[p*2 +: 2], state_reg.gpio_in_en[p]);
        end
        case (state_reg.power)
            cpm_pkg::CPM_ST_OFF: if (enabled) state_next.power = cpm_pkg::CPM_ST_RUN;
            cpm_pkg::CPM_ST_RUN: if (!enabled) state_next.power = cpm_pkg::CPM_ST_OFF;
            default: state_next.power = cpm_pkg::CPM_ST_OFF;
        endcase
        // Held at defaults and floating while powered down
        if (!enabled) begin
            // Default role general I/O, driven low
            state_next.func_sel   = `CPM_FUNC_SEL_RST;
            state_next.gpio_out   = `CPM_GPIO_OUT_RST;
            state_next.gpio_in_en = `CPM_GPIO_INEN_RST;
            state_next.pin_o      = 3'h0;
            state_next.pin_oe     = 3'h0;
            state_next.self_test  = 1'b0;
            state_next.clk_fixed  = 1'b0;
            state_next.int_in     = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '{power: cpm_pkg::CPM_ST_OFF, func_sel: `CPM_FUNC_SEL_RST, gpio_out: `CPM_GPIO_OUT_RST,
                           gpio_in_en: `CPM_GPIO_INEN_RST, ack: 1'b0, rdata: 32'h0, pin_o: 3'h0,
                           pin_oe: 3'h0, self_test: 1'b0, clk_fixed: 1'b0, int_in: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Weak pulldown on power-down input always on
    assign o_power_down_pulldown_en = 1'b1;
    // PLL and supply state from power state
    assign o_running          = (state_reg.power == cpm_pkg::CPM_ST_RUN);
    assign o_pll_enable       = o_running;
    assign o_low_power        = ~o_running;
    assign o_self_test_mode   = state_reg.self_test;
    assign o_test_clock_fixed = state_reg.clk_fixed;
    assign o_interrupt_input  = state_reg.int_in;
    assign o_general_io_o     = state_reg.pin_o;
    assign o_general_io_oe    = state_reg.pin_oe;
    assign o_avs_readdata     = state_reg.rdata;
    assign o_avs_waitrequest  = req & ~state_reg.ack;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    off_tristate_a: assert property (!o_running |-> o_general_io_oe == 3'h0 && !o_pll_enable && o_low_power)
        else $error("outputs driven or PLL on while powered down");
    off_follow_a: assert property (!enabled |=> !o_running && o_general_io_oe == 3'h0)
        else $error("power-down not followed");
    release_defaults_a: assert property ($rose(o_running) |-> state_reg.func_sel == `CPM_FUNC_SEL_RST
        && state_reg.gpio_out == `CPM_GPIO_OUT_RST && state_reg.gpio_in_en == `CPM_GPIO_INEN_RST)
        else $error("registers not at defaults on release");
    pulldown_on_a: assert property (o_power_down_pulldown_en)
        else $error("power-down pulldown disabled");
    self_test_pin_a: assert property (enabled |=> o_self_test_mode == $past(i_self_test_enable_pin))
        else $error("self-test mode does not follow its pin");
    clock_select_a: assert property (enabled && i_self_test_enable_pin |=>
        o_test_clock_fixed == $past(i_self_test_clock_select))
        else $error("test clock select wrong");
    shared_pin_a: assert property (enabled && !i_self_test_enable_pin |=>
        !o_test_clock_fixed && o_interrupt_input == $past(i_self_test_clock_select))
        else $error("shared pin role wrong");
    gpio_default_a: assert property (o_running && $past(o_running) && $past(state_reg.func_sel) == 6'h00
        && $past(state_reg.gpio_out) == 3'h0 && $past(state_reg.gpio_in_en) == 3'h0
        |-> o_general_io_oe == 3'h7 && o_general_io_o == 3'h0)
        else $error("general pins not driven low by default");
    pin0_audio_a: assert property (enabled && state_reg.func_sel[1:0] == 2'h1 |=>
        o_general_io_o[0] == $past(i_serial_audio_out))
        else $error("pin 0 audio alternate not routed");

    // Bus answer: one wait cycle, read data held while idle
    ack_pulse_a: assert property (state_reg.ack |=> !state_reg.ack)
        else $error("bus answer longer than one cycle");
    one_wait_a: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus wait longer than one cycle");
    rdata_hold_a: assert property (!req |=> $stable(o_avs_readdata))
        else $error("read data changed without a request");

    // Powered down: test roles off, pin roles kept at defaults
    off_roles_a: assert property (
        !o_running |-> !o_self_test_mode && !o_test_clock_fixed && !o_interrupt_input)
        else $error("test or interrupt role active while powered down");
    off_no_write_a: assert property (!o_running |=> state_reg.func_sel == `CPM_FUNC_SEL_RST)
        else $error("pin roles changed while powered down");

    // Alternate routes of the three pins
    pin0_pass_a: assert property (enabled && state_reg.func_sel[1:0] == 2'h2 |=>
        o_general_io_o[0] == $past(i_self_test_pass))
        else $error("pin 0 pass alternate not routed");
    pin1_alt_a: assert property (enabled && state_reg.func_sel[3:2] == 2'h1 |=>
        o_general_io_o[1] == $past(i_alt_function_pin1))
        else $error("pin 1 alternate not routed");
    pin2_lane_a: assert property (enabled && state_reg.func_sel[5:4] == 2'h1 |=>
        o_general_io_o[2] == $past(i_audio_data_lane_c))
        else $error("pin 2 audio lane not routed");
    pin_off_a: assert property (enabled && state_reg.func_sel[3:2] == 2'h3 |=> !o_general_io_oe[1])
        else $error("pin 1 driven in its off setting");

    cov_release_c: cover property (!o_running ##1 o_running);
    cov_write_c:   cover property (i_avs_write && !o_avs_waitrequest && i_avs_address == `CPM_ADDR_FUNC_SEL);
    cov_selftest_c: cover property (o_self_test_mode && o_test_clock_fixed);
    cov_pass_c:    cover property (state_reg.func_sel[1:0] == 2'h2 && o_general_io_o[0]);
    cov_intr_c:    cover property (o_interrupt_input);
endmodule
`default_nettype wire

// *** cpm_consts.svh ***
/*
 * Constants of the control pin and power-down mux: register offsets, field
 * positions, reset values and the release synchroniser depth.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

// Register byte offsets
`define CPM_ADDR_FUNC_SEL   4'h0
`define CPM_ADDR_GPIO_CTRL  4'h4
`define CPM_ADDR_STATUS     4'h8

// Field positions
`define CPM_FSEL_W          2
`define CPM_CTRL_OUT_LSB    0
`define CPM_CTRL_INEN_LSB   4
`define CPM_STAT_PIN_LSB    0
`define CPM_STAT_SELFTEST   4
`define CPM_STAT_CLKFIX     5
`define CPM_STAT_INT        6
`define CPM_STAT_RUN        7

// Reset values
`define CPM_FUNC_SEL_RST    6'h00
`define CPM_GPIO_OUT_RST    3'h0
`define CPM_GPIO_INEN_RST   3'h0

// Release synchroniser depth
`define CPM_SYNC_STAGES     2

`endif

// *** cpm_pkg.sv ***
/*
 * Types of the control pin and power-down mux: power state, pin function
 * selection and the packed state of the top module.
 * Assumes cpm_consts.svh is on the include path.
 */
`default_nettype none
`include "cpm_consts.svh"
package cpm_pkg;
    typedef enum logic {
        CPM_ST_OFF,
        CPM_ST_RUN
    } cpm_power_e;

    // Function codes in the select field: general I/O, first and second alternate
    typedef enum logic [1:0] {
        CPM_FUNC_GPIO,
        CPM_FUNC_ALT1,
        CPM_FUNC_ALT2,
        CPM_FUNC_RSVD
    } cpm_pin_func_e;

    typedef struct packed {
        cpm_power_e   power;
        logic [5:0]   func_sel;
        logic [2:0]   gpio_out;
        logic [2:0]   gpio_in_en;
        logic         ack;
        logic [31:0]  rdata;
        logic [2:0]   pin_o;
        logic [2:0]   pin_oe;
        logic         self_test;
        logic         clk_fixed;
        logic         int_in;
    } cpm_state_s;
endpackage
`default_nettype wire

// *** cpm_release_sync.sv ***
/*
 * Power-down release synchroniser: assertion of power-down is immediate,
 * release is passed through two flip-flops onto the clock.
 * Assumes the clock runs whenever power-down is released.
 */
`default_nettype none
`include "cpm_consts.svh"
module cpm_release_sync (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_power_down_n_input,
    output var  logic o_enabled
);
    logic [`CPM_SYNC_STAGES-1:0] sync_reg;
    logic                        clear;

    // Low power-down clears the chain at once
    assign clear = i_rst | ~i_power_down_n_input;

    always_ff @(posedge i_clock or posedge clear) begin
        if (clear) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[`CPM_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign o_enabled = sync_reg[`CPM_SYNC_STAGES-1];

    // Enabled only while power-down is high and was high before
    en_needs_pin_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_enabled |-> i_power_down_n_input && $past(i_power_down_n_input))
        else $error("enable without held power-down release");
endmodule
`default_nettype wire

// *** cpm_host_model.sv ***
/*
 * Host processor model driving the power-down line of the control pin mux.
 * Assumes the bench gives supply-ready, release and drive commands on i_clock.
 */
`default_nettype none
module cpm_host_model (
    input  wire logic i_clock,
    input  wire logic i_supply_ok,
    input  wire logic i_release,
    input  wire logic i_drive,
    output var  logic o_power_down_n_input
);
    timeunit 1ns;
    timeprecision 1ns;
    logic level_reg;

    always_ff @(posedge i_clock) begin
        level_reg <= i_supply_ok & i_release;
    end

    assign o_power_down_n_input = i_drive ? level_reg : 1'b0;
endmodule
`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench of the control pin mux: pins, power-down and Avalon-MM registers.
 * Assumes cpm_top with one wait cycle per bus access and registered pin outputs.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 1'b0, i_rst = 1'b1, pd_n, sup_ok = 1'b0, rel = 1'b0, drv = 1'b0;
    logic st_en = 1'b0, st_sel = 1'b0, s_out = 1'b1, s_pass = 1'b1, s_alt = 1'b0, s_lc = 1'b1;
    logic [2:0] gio_i = 3'h6;
    logic [2:0] gio_o, gio_oe;
    logic [3:0] addr = 4'h0, be = 4'hf;
    logic rd = 1'b0, wr = 1'b0, wreq, pden, pll, lowp, run, mode, fixd, intr;
    logic [31:0] wdat = 32'h0, rdat, d;
    int fail_count = 0, tests_run = 0, cycles = 0;

    cpm_host_model u_cpm_host_model (.i_clock(i_clock), .i_supply_ok(sup_ok), .i_release(rel),
        .i_drive(drv), .o_power_down_n_input(pd_n));
    cpm_top u_cpm_top (.i_clock(i_clock), .i_rst(i_rst), .i_power_down_n_input(pd_n),
        .o_power_down_pulldown_en(pden), .o_pll_enable(pll), .o_low_power(lowp), .o_running(run),
        .i_self_test_enable_pin(st_en), .i_self_test_clock_select(st_sel), .o_self_test_mode(mode),
        .o_test_clock_fixed(fixd), .o_interrupt_input(intr), .i_serial_audio_out(s_out),
        .i_self_test_pass(s_pass), .i_alt_function_pin1(s_alt), .i_audio_data_lane_c(s_lc),
        .i_general_io_i(gio_i), .o_general_io_o(gio_o), .o_general_io_oe(gio_oe),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq));

    // Clock at 40 MHz
    always #12.5 i_clock = ~i_clock;

    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus write held until waitrequest is sampled low
    task automatic bus_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] b);
        @(posedge i_clock);
        addr <= a;
        wdat <= v;
        be <= b;
        wr <= 1'b1;
        do @(posedge i_clock); while (wreq !== 1'b0);
        wr <= 1'b0;
    endtask

    // Bus read, data taken at the edge that ends the wait
    task automatic bus_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        do @(posedge i_clock); while (wreq !== 1'b0);
        v = rdat;
        rd <= 1'b0;
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic power_up;
        @(posedge i_clock);
        rel <= 1'b1;
        while (run !== 1'b1) @(posedge i_clock);
        look(2);
    endtask

    initial begin
        // Held in reset and powered down
        look(5);
        check({pden, lowp, run, pll, gio_oe}, {4'b1100, 3'h0});
        @(posedge i_clock);
        i_rst <= 1'b0;
        drv <= 1'b1;
        rel <= 1'b1;
        // Release requested before supplies: still off, writes ignored
        bus_write(4'h4, 32'h7, 4'hf);
        look(4);
        check({run, lowp, gio_oe}, {2'b01, 3'h0});
        @(posedge i_clock);
        sup_ok <= 1'b1;
        power_up();
        check({run, pll, lowp, gio_oe, gio_o}, {3'b110, 3'h7, 3'h0});
        bus_read(4'h4, d);
        check(d, 32'h0);
        // Output value and input enables
        bus_write(4'h4, 32'h35, 4'hf);
        look(2);
        check({gio_oe, gio_o[2]}, {3'h4, 1'b1});
        bus_read(4'h4, d);
        check(d, 32'h35);
        // Alternate functions of every pin
        bus_write(4'h4, 32'h0, 4'hf);
        bus_write(4'h0, 32'h15, 4'hf);
        look(2);
        check({gio_oe, gio_o}, {3'h7, 3'h5});
        @(posedge i_clock);
        s_out <= 1'b0;
        s_alt <= 1'b1;
        s_lc <= 1'b0;
        look(2);
        check({gio_oe, gio_o}, {3'h7, 3'h2});
        bus_write(4'h0, 32'h3e, 4'hf);
        look(2);
        check({gio_oe, gio_o[0]}, {3'h1, 1'b1});
        @(posedge i_clock);
        s_pass <= 1'b0;
        look(2);
        check({gio_oe, gio_o[0]}, {3'h1, 1'b0});
        bus_write(4'h0, 32'h0, 4'he);
        bus_read(4'h0, d);
        check(d, 32'h3e);
        bus_write(4'hc, 32'hff, 4'hf);
        bus_read(4'hc, d);
        check(d, 32'h0);
        // Self-test and shared pin, all four pin combinations
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clock);
            st_en <= k[1];
            st_sel <= k[0];
            gio_i <= ~k[2:0];
            look(2);
            check({mode, fixd, intr}, {k[1], k[1] & k[0], ~k[1] & k[0]});
            bus_read(4'h8, d);
            check(d, {24'h0, 1'b1, ~k[1] & k[0], k[1] & k[0], k[1], 1'b0, ~k[2:0]});
        end
        // Power down mid-run, then back to defaults
        @(posedge i_clock);
        rel <= 1'b0;
        look(4);
        check({run, pll, lowp, gio_oe}, {3'b001, 3'h0});
        power_up();
        bus_read(4'h0, d);
        check(d, 32'h0);
        check({gio_oe, gio_o}, {3'h7, 3'h0});
        report_and_stop();
    end
endmodule
`default_nettype wire
